// >>> rcp_char_proc.sv
// Purpose : Receive character processing (matching, translation, break and
//           error handling) with a small transmit translation path
// Assumes : Receiver, host FIFO and transmitter run on MCLK
// Notes   : One character in flight per direction; a second output slot
//           carries the tail of two-character sequences
`timescale 1ns/100ps

module rcp_char_proc
   import rcp_pkg::*;
(
   input  wire logic                          MCLK,          // System clock
   input  wire logic                          NRST,          // Sync reset, low
   input  wire logic [rcp_pkg::ADDR_W-1:0]    ADDRESS,       // Word index
   input  wire logic                          READ,          // Read request
   input  wire logic                          WRITE,         // Write request
   input  wire logic [rcp_pkg::DATA_W-1:0]    WRITEDATA,     // Write data
   output logic      [rcp_pkg::DATA_W-1:0]    READDATA,      // Read data
   output logic                               WAITREQUEST,   // Bus stall
   input  wire logic                          RX_VALID,      // Char offered
   input  wire logic [rcp_pkg::CHAR_W-1:0]    RX_DATA,       // Received char
   input  wire logic                          RX_PERR,       // Parity error
   input  wire logic                          RX_FERR,       // Framing error
   input  wire logic                          RX_OERR,       // Overrun error
   input  wire logic                          RX_BREAK,      // Break received
   output logic                               RX_READY,      // Char taken
   output logic                               OUT_VALID,     // Char to host
   output logic      [rcp_pkg::CHAR_W-1:0]    OUT_DATA,      // Processed char
   output logic                               OUT_EXCEPT,    // Exception flag
   output logic      [2:0]                    OUT_CODE,      // Detect code
   output logic      [3:0]                    OUT_ERRS,      // Brk,O,F,P
   input  wire logic                          OUT_READY,     // Host takes char
   input  wire logic [rcp_pkg::CNT_W-1:0]     FIFO_COUNT,    // Good chars held
   output logic                               DATA_REQ,      // Threshold met
   output logic                               FLOW_XON,      // XON seen, pulse
   output logic                               FLOW_XOFF,     // XOFF seen, pulse
   input  wire logic                          TX_IN_VALID,   // Tx char offered
   input  wire logic [rcp_pkg::CHAR_W-1:0]    TX_IN_DATA,    // Tx char
   output logic                               TX_IN_READY,   // Tx char taken
   output logic                               TX_OUT_VALID,  // Tx char out
   output logic      [rcp_pkg::CHAR_W-1:0]    TX_OUT_DATA,   // Translated char
   input  wire logic                          TX_OUT_READY   // Shifter takes
);
   import rcp_pkg::*;

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [7:0]  detect_reg;
   logic [7:0]  handling_reg;
   logic [7:0]  strip_reg;
   logic [7:0]  control_reg;
   logic [7:0]  special_reg [4];
   logic [7:0]  range_lo_reg;
   logic [7:0]  range_hi_reg;
   logic        ack_reg;
   logic [31:0] rdata_reg;
   logic        out_valid_reg;
   logic [7:0]  out_data_reg;
   logic        out_exc_reg;
   logic [2:0]  out_code_reg;
   logic [3:0]  out_errs_reg;
   logic        pend_valid_reg;
   logic [7:0]  pend_data_reg;
   logic        xon_reg;
   logic        xoff_reg;
   logic        flow_off_reg;
   logic [2:0]  last_code_reg;
   logic        tx_valid_reg;
   logic [7:0]  tx_data_reg;
   logic        tx_pend_reg;
   logic        data_req_reg;

   // Processing results
   logic [7:0]  ch;
   logic        errd;
   logic        may_match;
   logic        m1;
   logic        m2;
   logic        m3;
   logic        m4;
   logic        in_range;
   logic        keep;
   logic [7:0]  d0;
   logic        exc;
   logic [2:0]  code;
   logic        two;
   logic [7:0]  d1;
   logic        do_xon;
   logic        do_xoff;
   logic        rx_take;
   logic        out_pop;
   logic        wr_now;
   logic        tx_take;
   logic        tx_pop;
   logic [7:0]  tx_xl;
   logic        tx_two;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Threshold legal for the current format
   function automatic logic thr_ok(input logic par, input logic [7:0] opt);
      logic [4:0] t;
      t = par ? opt[4:0] : {1'b0, opt[3:0]};
      thr_ok = (t != 5'h00) && (t <= (par ? THR_MAX_PAR : THR_MAX_SER));
   endfunction : thr_ok

   // ------------------------------------------------------------
   // Avalon-MM slave
   // ------------------------------------------------------------
   // Every access stalls one cycle so read data come from a flop
   assign WAITREQUEST = (READ || WRITE) && !ack_reg;
   assign READDATA    = rdata_reg;
   assign wr_now      = WRITE && ack_reg;

   // Acknowledge toggles once per access
   always_ff @(posedge MCLK)
   begin
      if (!NRST)
         ack_reg <= 1'b0;
      else
         ack_reg <= (READ || WRITE) && !ack_reg;
   end

   // Read mux; unmapped indexes read zero
   always_ff @(posedge MCLK)
   begin
      if (!NRST)
         rdata_reg <= 32'h0000_0000;
      else if (READ && !ack_reg)
      begin
         case (ADDRESS)
            IDX_DETECT_THR:  rdata_reg <= {24'h00_0000, detect_reg};
            IDX_SPECIAL_1:   rdata_reg <= {24'h00_0000, special_reg[0]};
            IDX_SPECIAL_2:   rdata_reg <= {24'h00_0000, special_reg[1]};
            IDX_SPECIAL_3:   rdata_reg <= {24'h00_0000, special_reg[2]};
            IDX_SPECIAL_4:   rdata_reg <= {24'h00_0000, special_reg[3]};
            IDX_RX_HANDLING: rdata_reg <= {24'h00_0000, handling_reg};
            IDX_STRIP_XLATE: rdata_reg <= {24'h00_0000, strip_reg};
            IDX_CONTROL:     rdata_reg <= {24'h00_0000, control_reg};
            IDX_RANGE_LOW:   rdata_reg <= {24'h00_0000, range_lo_reg};
            IDX_RANGE_HIGH:  rdata_reg <= {24'h00_0000, range_hi_reg};
            IDX_STATUS:      rdata_reg <= {24'h00_0000, data_req_reg, flow_off_reg,
                                           out_valid_reg, 2'b00, last_code_reg};
            default:         rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // Register writes take effect on the acknowledging edge
   always_ff @(posedge MCLK)
   begin
      if (!NRST)
      begin
         detect_reg     <= REG_RESET;
         handling_reg   <= REG_RESET;
         strip_reg      <= REG_RESET;
         control_reg    <= REG_RESET;
         range_lo_reg   <= REG_RESET;
         range_hi_reg   <= REG_RESET;
         for (int i = 0; i < 4; i++)
            special_reg[i] <= REG_RESET;
      end
      else if (wr_now)
      begin
         case (ADDRESS)
            IDX_DETECT_THR:  detect_reg     <= WRITEDATA[7:0];
            IDX_SPECIAL_1:   special_reg[0] <= WRITEDATA[7:0];
            IDX_SPECIAL_2:   special_reg[1] <= WRITEDATA[7:0];
            IDX_SPECIAL_3:   special_reg[2] <= WRITEDATA[7:0];
            IDX_SPECIAL_4:   special_reg[3] <= WRITEDATA[7:0];
            IDX_RX_HANDLING: handling_reg   <= WRITEDATA[7:0];
            IDX_STRIP_XLATE: strip_reg      <= WRITEDATA[7:0];
            IDX_CONTROL:     control_reg    <= WRITEDATA[7:0];
            IDX_RANGE_LOW:   range_lo_reg   <= WRITEDATA[7:0];
            IDX_RANGE_HIGH:  range_hi_reg   <= WRITEDATA[7:0];
            default:         control_reg    <= control_reg;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Receive character decision
   // ------------------------------------------------------------
   // Matching is decided first so a matched char skips later steps
   always_comb
   begin
      ch = RX_DATA;
      if (strip_reg[SX_MSB_STRIP])
         ch[7] = 1'b0;
      errd      = RX_PERR || RX_FERR || RX_OERR;
      may_match = !RX_BREAK && (!errd || strip_reg[SX_MATCH_ERR]);
      m1 = may_match && detect_reg[DT_MATCH12_EN] && (ch == special_reg[0]);
      m2 = may_match && detect_reg[DT_MATCH12_EN] && (ch == special_reg[1]);
      m3 = may_match && detect_reg[DT_MATCH34_EN] && (ch == special_reg[2]);
      m4 = may_match && detect_reg[DT_MATCH34_EN] && (ch == special_reg[3]);
      in_range = may_match && detect_reg[DT_RANGE_EN]
                 && (ch >= range_lo_reg) && (ch <= range_hi_reg);
      keep    = 1'b1;
      d0      = ch;
      exc     = 1'b0;
      code    = CODE_NONE;
      two     = 1'b0;
      d1      = CH_NULL;
      do_xon  = 1'b0;
      do_xoff = 1'b0;
      if (m1 || m2)
      begin
         // Flow chars act only with in-band enabled on top of match enable
         do_xon  = m1 && control_reg[CT_INBAND];
         do_xoff = m2 && !m1 && control_reg[CT_INBAND];
         if (detect_reg[DT_FLOW_TRANS])
            keep = 1'b0;
         else
         begin
            exc  = 1'b1;
            code = m1 ? CODE_SC1 : CODE_SC2;
         end
      end
      else if (m3 || m4)
      begin
         exc  = 1'b1;
         code = m3 ? CODE_SC3 : CODE_SC4;
      end
      else if (in_range)
      begin
         exc  = 1'b1;
         code = CODE_RANGE;
      end
      else if (RX_BREAK)
      begin
         d0 = CH_NULL;
         case ({handling_reg[RH_BRK_IGN], handling_reg[RH_BRK_SUPP]})
            2'b00:   exc  = 1'b1;
            2'b01:   exc  = 1'b0;
            2'b11:   keep = 1'b0;
            default: exc  = 1'b1;                                // Unused, safe report
         endcase
      end
      else if (errd)
      begin
         case (handling_reg[2:0])
            EH_EXCEPT: exc  = 1'b1;
            EH_GOOD:   exc  = 1'b0;
            EH_DROP:   keep = 1'b0;
            EH_NULL:   d0   = CH_NULL;
            EH_ESCAPE:
            begin
               d0  = CH_ALLONES;
               two = 1'b1;
               d1  = CH_NULL;
            end
            default:   exc  = 1'b1;                              // Unused codes
         endcase
      end
      else
      begin
         // Return and newline translation on good chars
         if (ch == CH_RETURN)
         begin
            if (handling_reg[RH_RET_DISC])
               keep = 1'b0;
            else if (handling_reg[RH_RET2NL])
               d0 = CH_NEWLINE;
         end
         else if (ch == CH_NEWLINE)
         begin
            if (handling_reg[RH_NL2RET])
               d0 = CH_RETURN;
         end
         else if ((ch == CH_ALLONES) && (handling_reg[2:0] == EH_ESCAPE))
         begin
            two = 1'b1;
            d1  = CH_ALLONES;
         end
      end
   end

   // ------------------------------------------------------------
   // Receive output slot
   // ------------------------------------------------------------
   // One char at a time; the pending slot holds the second of a pair
   assign RX_READY = !out_valid_reg;
   assign rx_take  = RX_VALID && !out_valid_reg;
   assign out_pop  = out_valid_reg && OUT_READY;

   always_ff @(posedge MCLK)
   begin
      if (!NRST)
      begin
         out_valid_reg  <= 1'b0;
         out_data_reg   <= CH_NULL;
         out_exc_reg    <= 1'b0;
         out_code_reg   <= CODE_NONE;
         out_errs_reg   <= 4'h0;
         pend_valid_reg <= 1'b0;
         pend_data_reg  <= CH_NULL;
      end
      else if (rx_take)
      begin
         out_valid_reg  <= keep;
         out_data_reg   <= d0;
         out_exc_reg    <= exc;
         out_code_reg   <= code;
         out_errs_reg   <= exc ? {RX_BREAK, RX_OERR, RX_FERR, RX_PERR} : 4'h0;
         pend_valid_reg <= keep && two;
         pend_data_reg  <= d1;
      end
      else if (out_pop)
      begin
         out_valid_reg  <= pend_valid_reg;
         out_data_reg   <= pend_data_reg;
         out_exc_reg    <= 1'b0;
         out_code_reg   <= CODE_NONE;
         out_errs_reg   <= 4'h0;
         pend_valid_reg <= 1'b0;
      end
   end

   assign OUT_VALID  = out_valid_reg;
   assign OUT_DATA   = out_data_reg;
   assign OUT_EXCEPT = out_exc_reg;
   assign OUT_CODE   = out_code_reg;
   assign OUT_ERRS   = out_errs_reg;

   // ------------------------------------------------------------
   // Flow control state and status
   // ------------------------------------------------------------
   // XOFF holds the transmit path; XON releases it
   always_ff @(posedge MCLK)
   begin
      if (!NRST)
      begin
         xon_reg       <= 1'b0;
         xoff_reg      <= 1'b0;
         flow_off_reg  <= 1'b0;
         last_code_reg <= CODE_NONE;
      end
      else
      begin
         xon_reg  <= rx_take && do_xon;
         xoff_reg <= rx_take && do_xoff;
         if (rx_take && do_xoff)
            flow_off_reg <= 1'b1;
         else if (rx_take && do_xon)
            flow_off_reg <= 1'b0;
         if (rx_take && keep && exc)
            last_code_reg <= code;
      end
   end

   assign FLOW_XON  = xon_reg;
   assign FLOW_XOFF = xoff_reg;

   // Data request from threshold; illegal codes never request
   always_ff @(posedge MCLK)
   begin
      if (!NRST)
         data_req_reg <= 1'b0;
      else if (control_reg[CT_PARALLEL])
         data_req_reg <= thr_ok(1'b1, detect_reg)
                         && (FIFO_COUNT >= detect_reg[4:0]);
      else
         data_req_reg <= thr_ok(1'b0, detect_reg)
                         && (FIFO_COUNT >= {1'b0, detect_reg[3:0]});
   end

   assign DATA_REQ = data_req_reg;

   // ------------------------------------------------------------
   // Transmit translation
   // ------------------------------------------------------------
   // Expansion emits return now and, with SX_RET2NL_TX also set, newline from the pending flag
   always_comb
   begin
      tx_xl  = TX_IN_DATA;
      tx_two = 1'b0;
      if ((TX_IN_DATA == CH_RETURN) && strip_reg[SX_RET2NL_TX])
         tx_xl = CH_NEWLINE;
      else if ((TX_IN_DATA == CH_NEWLINE) && strip_reg[SX_NL_EXPAND])
      begin
         tx_xl  = CH_RETURN;
         tx_two = strip_reg[SX_RET2NL_TX];
      end
   end

   assign TX_IN_READY = !tx_valid_reg && !flow_off_reg;
   assign tx_take     = TX_IN_VALID && TX_IN_READY;
   assign tx_pop      = tx_valid_reg && TX_OUT_READY;

   always_ff @(posedge MCLK)
   begin
      if (!NRST)
      begin
         tx_valid_reg <= 1'b0;
         tx_data_reg  <= CH_NULL;
         tx_pend_reg  <= 1'b0;
      end
      else if (tx_take)
      begin
         tx_valid_reg <= 1'b1;
         tx_data_reg  <= tx_xl;
         tx_pend_reg  <= tx_two;
      end
      else if (tx_pop)
      begin
         tx_valid_reg <= tx_pend_reg;
         tx_data_reg  <= CH_NEWLINE;
         tx_pend_reg  <= 1'b0;
      end
   end

   assign TX_OUT_VALID = tx_valid_reg;
   assign TX_OUT_DATA  = tx_data_reg;
endmodule : rcp_char_proc

// >>> rcp_pkg.sv
// Purpose : Constants for the receive character processing block
// Assumes : Avalon-MM word addressing, one register per word
// Notes   : All offsets are word indexes; byte address is four times the index
package rcp_pkg;
   // ------------------------------------------------------------
   // Bus and data widths
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned CHAR_W = 8;
   localparam int unsigned CNT_W  = 5;

   // ------------------------------------------------------------
   // Register indexes
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_DETECT_THR  = 8'h0A;
   localparam logic [7:0] IDX_SPECIAL_1   = 8'h1A;
   localparam logic [7:0] IDX_SPECIAL_2   = 8'h1B;
   localparam logic [7:0] IDX_SPECIAL_3   = 8'h1C;
   localparam logic [7:0] IDX_SPECIAL_4   = 8'h1D;
   localparam logic [7:0] IDX_RX_HANDLING = 8'h1E;
   localparam logic [7:0] IDX_STRIP_XLATE = 8'h1F;
   localparam logic [7:0] IDX_CONTROL     = 8'h20;
   localparam logic [7:0] IDX_RANGE_LOW   = 8'h21;
   localparam logic [7:0] IDX_RANGE_HIGH  = 8'h22;
   localparam logic [7:0] IDX_STATUS      = 8'h23;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int unsigned DT_RANGE_EN   = 7;
   localparam int unsigned DT_MATCH34_EN = 6;
   localparam int unsigned DT_FLOW_TRANS = 5;
   localparam int unsigned DT_MATCH12_EN = 4;
   localparam int unsigned RH_RET_DISC   = 7;
   localparam int unsigned RH_RET2NL     = 6;
   localparam int unsigned RH_NL2RET     = 5;
   localparam int unsigned RH_BRK_IGN    = 4;
   localparam int unsigned RH_BRK_SUPP   = 3;
   localparam int unsigned SX_MSB_STRIP  = 7;
   localparam int unsigned SX_MATCH_ERR  = 5;
   localparam int unsigned SX_NL_EXPAND  = 1;
   localparam int unsigned SX_RET2NL_TX  = 0;
   localparam int unsigned CT_PARALLEL   = 0;
   localparam int unsigned CT_INBAND     = 1;

   // ------------------------------------------------------------
   // Characters, codes, limits, reset values
   // ------------------------------------------------------------
   localparam logic [7:0] CH_RETURN  = 8'h0D;
   localparam logic [7:0] CH_NEWLINE = 8'h0A;
   localparam logic [7:0] CH_ALLONES = 8'hFF;
   localparam logic [7:0] CH_NULL    = 8'h00;
   localparam logic [2:0] CODE_NONE  = 3'h0;
   localparam logic [2:0] CODE_SC1   = 3'h1;
   localparam logic [2:0] CODE_SC2   = 3'h2;
   localparam logic [2:0] CODE_SC3   = 3'h3;
   localparam logic [2:0] CODE_SC4   = 3'h4;
   localparam logic [2:0] CODE_RANGE = 3'h7;
   localparam logic [2:0] EH_EXCEPT  = 3'h0;
   localparam logic [2:0] EH_GOOD    = 3'h1;
   localparam logic [2:0] EH_DROP    = 3'h2;
   localparam logic [2:0] EH_NULL    = 3'h3;
   localparam logic [2:0] EH_ESCAPE  = 3'h4;
   localparam logic [4:0] THR_MAX_SER = 5'h0C;
   localparam logic [4:0] THR_MAX_PAR = 5'h1E;
   localparam logic [7:0] REG_RESET  = 8'h00;
endpackage : rcp_pkg

// >>> rcp_checker_assertions.sv
// Purpose : Port checks for rcp_char_proc
// Assumes : One clock, NRST low resets
// Notes   : Bound to every instance below
`timescale 1ns/100ps
module rcp_checker (
   input wire logic       MCLK,        // Clock
   input wire logic       NRST,        // Reset, low
   input wire logic       READ,        // Bus read
   input wire logic       WRITE,       // Bus write
   input wire logic       WAITREQUEST, // Bus stall
   input wire logic       RX_VALID,    // Char offered
   input wire logic       RX_READY,    // Char taken
   input wire logic       OUT_VALID,   // Host char
   input wire logic       OUT_READY,   // Host takes
   input wire logic [7:0] OUT_DATA,    // Host data
   input wire logic       OUT_EXCEPT,  // Exception
   input wire logic [2:0] OUT_CODE,    // Detect code
   input wire logic [3:0] OUT_ERRS,    // Error flags
   input wire logic [4:0] FIFO_COUNT,  // Host fill
   input wire logic       DATA_REQ,    // Threshold met
   input wire logic       FLOW_XON,    // Resume pulse
   input wire logic       FLOW_XOFF    // Stop pulse
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!NRST);
   // A fresh request stalls one cycle, then is answered
   bus_wait_a: assert property ((READ || WRITE) && !$past(READ || WRITE) |-> WAITREQUEST ##1 !WAITREQUEST)
      else $error("bus answer late");
   // Only one char in flight, so a full slot refuses input
   rx_refuse_a: assert property (OUT_VALID |-> !RX_READY)
      else $error("char taken while full");
   out_hold_a: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA))
      else $error("host char lost");
   err_except_a: assert property (OUT_VALID && OUT_ERRS != 4'h0 |-> OUT_EXCEPT)
      else $error("error flags without exception");
   code_except_a: assert property (OUT_VALID && OUT_CODE != 3'h0 |-> OUT_EXCEPT)
      else $error("match without exception");
   // Flow chars may arrive back to back, but one char never means both
   flow_pulse_a: assert property (!(FLOW_XON && FLOW_XOFF))
      else $error("both flow pulses at once");
   flow_cause_a: assert property (FLOW_XON || FLOW_XOFF |-> $past(RX_VALID && RX_READY))
      else $error("flow pulse without char");
   out_cause_a: assert property ($rose(OUT_VALID) |-> $past(RX_VALID && RX_READY))
      else $error("host char from nothing");
   dreq_zero_a: assert property (DATA_REQ |-> $past(FIFO_COUNT) != 5'h00)
      else $error("request with empty fifo");
   cover property (OUT_VALID && OUT_CODE == 3'h7);
   cover property (FLOW_XOFF);
   cover property (OUT_VALID && !OUT_READY);
endmodule : rcp_checker
bind rcp_char_proc rcp_checker chk_u (.*);

// >>> rcp_host_model.sv
// Purpose : Host side taking chars from rcp_char_proc
// Assumes : Takes every char unless stalled
// Notes   : Drain empties the FIFO at once
`timescale 1ns/100ps
module rcp_host_model (
   input  wire logic       mclk,       // Clock
   input  wire logic       nrst,       // Reset, low
   input  wire logic       out_valid,  // Char offered
   input  wire logic       out_except, // Exception flag
   input  wire logic       stall,      // Hold off
   input  wire logic       drain,      // Empty FIFO
   output logic            out_ready,  // Taking chars
   output logic [4:0]      fifo_count  // Good chars
);
   // Only good chars count toward the threshold
   always_ff @(posedge mclk)
   begin
      out_ready <= nrst && !stall;
      if (!nrst || drain) fifo_count <= 5'h00;
      else if (out_valid && out_ready && !out_except) fifo_count <= fifo_count + 5'h01;
   end
endmodule : rcp_host_model

// >>> tb_top.sv
// Purpose : Self-checking bench for rcp_char_proc
// Assumes : Host ready unless stalled
// Notes   : Transmit path tried once with newline expansion
`timescale 1ns/100ps
`define CK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t %h %h", $time, a, b); end end
module tb_top;
   import rcp_pkg::*;
   typedef struct packed {logic [7:0] h; logic [7:0] c; logic [3:0] e; logic [1:0] n; logic [11:0] x0, x1;} rcp_row_s;
   localparam rcp_row_s ROWS [16] = '{
      '{8'h20, 8'h0A, 4'h0, 2'h1, 12'h00D, 12'h0}, '{8'h40, 8'h0D, 4'h0, 2'h1, 12'h00A, 12'h0},
      '{8'h60, 8'h0A, 4'h0, 2'h1, 12'h00D, 12'h0}, '{8'h60, 8'h0D, 4'h0, 2'h1, 12'h00A, 12'h0},
      '{8'hC0, 8'h0D, 4'h0, 2'h0, 12'h000, 12'h0}, '{8'hA0, 8'h0A, 4'h0, 2'h1, 12'h00D, 12'h0},
      '{8'h80, 8'h0A, 4'h0, 2'h1, 12'h00A, 12'h0}, '{8'h00, 8'h00, 4'h8, 2'h1, 12'h800, 12'h0},
      '{8'h08, 8'h00, 4'h8, 2'h1, 12'h000, 12'h0}, '{8'h18, 8'h00, 4'h8, 2'h0, 12'h000, 12'h0},
      '{8'h00, 8'h55, 4'h1, 2'h1, 12'h855, 12'h0}, '{8'h01, 8'h55, 4'h2, 2'h1, 12'h055, 12'h0},
      '{8'h02, 8'h55, 4'h4, 2'h0, 12'h000, 12'h0}, '{8'h03, 8'h55, 4'h1, 2'h1, 12'h000, 12'h0},
      '{8'h04, 8'h55, 4'h1, 2'h2, 12'h0FF, 12'h000}, '{8'h04, 8'hFF, 4'h0, 2'h2, 12'h0FF, 12'h0FF}};
   localparam logic [7:0] RC [4] = '{8'h3F, 8'h40, 8'h45, 8'h46};
   logic MCLK = 0, NRST = 0, READ = 0, WRITE = 0, RX_VALID = 0, stall = 0, drain = 0, WAITREQUEST, RX_READY;
   logic OUT_VALID, OUT_EXCEPT, OUT_READY, DATA_REQ, FLOW_XON, FLOW_XOFF;
   logic [7:0]  ADDRESS = 8'h00, RX_DATA = 8'h00, OUT_DATA;
   logic [31:0] WRITEDATA = 32'h0, READDATA, rd;
   logic [3:0]  err = 4'h0, OUT_ERRS, last_errs = 4'h0;
   logic        TX_IN_VALID = 0, TX_IN_READY, TX_OUT_VALID;
   logic [7:0]  TX_IN_DATA = 8'h00, TX_OUT_DATA;
   logic [2:0]  OUT_CODE;
   logic [4:0]  FIFO_COUNT;
   logic [11:0] q [$];
   int          fail_count = 0, n_checks = 0, cyc = 0, nxon = 0, nxoff = 0;
   rcp_char_proc dut_u (.*, .RX_PERR(err[0]), .RX_FERR(err[1]), .RX_OERR(err[2]), .RX_BREAK(err[3]),
      .TX_OUT_READY(1'b1));
   rcp_host_model host_u (.mclk(MCLK), .nrst(NRST), .out_valid(OUT_VALID), .out_except(OUT_EXCEPT), .stall(stall),
      .drain(drain), .out_ready(OUT_READY), .fifo_count(FIFO_COUNT));
   initial forever #5 MCLK = ~MCLK;
   // Collect host chars and flow pulses; cut a hang short
   always @(posedge MCLK)
   begin
      if (OUT_VALID && OUT_READY) q.push_back({OUT_EXCEPT, OUT_CODE, OUT_DATA});
      if (OUT_VALID && OUT_READY) last_errs <= OUT_ERRS;
      if (TX_OUT_VALID) q.push_back({4'h0, TX_OUT_DATA});
      nxon += FLOW_XON;
      nxoff += FLOW_XOFF;
      if (++cyc == 20000) begin fail_count++; test_done(); end
   end
   task automatic test_done();
      if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   // Request held until waitrequest seen low at an edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      {READ, WRITE, ADDRESS, WRITEDATA} <= {!w, w, a, d};
      do @(posedge MCLK); while (WAITREQUEST !== 1'b0);
      rd = READDATA;
      {READ, WRITE} <= 2'h0;
   endtask : bus
   task automatic send(input logic [7:0] c, input logic [3:0] e);
      @(posedge MCLK);
      {RX_VALID, RX_DATA, err} <= {1'b1, c, e};
      do @(posedge MCLK); while (RX_READY !== 1'b1);
      {RX_VALID, RX_DATA} <= {1'b0, ~c};
      repeat (6) @(posedge MCLK);
   endtask : send
   task automatic expect_out(input logic [1:0] n, input logic [11:0] x0, input logic [11:0] x1);
      `CK(q.size(), int'(n))
      if (n > 2'h0 && q.size() > 0) `CK(q[0], x0)
      if (n > 2'h1 && q.size() > 1) `CK(q[1], x1)
      q.delete();
   endtask : expect_out
   initial
   begin
      repeat (16) @(posedge MCLK);
      NRST <= 1;
      bus(1, 8'h30, 32'hFF);
      foreach (RC[i])
      begin
         bus(1'b0, i < 3 ? 8'h1E + i[7:0] : 8'h30, 32'h0);
         `CK(rd, {24'h0, REG_RESET})
      end
      foreach (ROWS[i])
      begin
         bus(1, IDX_RX_HANDLING, {24'h0, ROWS[i].h});
         bus(0, IDX_RX_HANDLING, 32'h0);
         `CK(rd, {24'h0, ROWS[i].h})
         send(ROWS[i].c, ROWS[i].e);
         expect_out(ROWS[i].n, ROWS[i].x0, ROWS[i].x1);
         `CK(last_errs, ROWS[i].x0[11] ? ROWS[i].e : 4'h0)
      end
      bus(1, IDX_RX_HANDLING, 32'h0);
      bus(1, IDX_RANGE_LOW, 32'h40);
      bus(1, IDX_RANGE_HIGH, 32'h45);
      bus(1, IDX_DETECT_THR, 32'h80);
      foreach (RC[i])
      begin
         send(RC[i], 4'h0);
         expect_out(2'h1, {((RC[i] inside {[8'h40:8'h45]}) ? 4'hF : 4'h0), RC[i]}, 12'h0);
      end
      bus(1, IDX_SPECIAL_3, 32'h22);
      bus(1, IDX_DETECT_THR, 32'h40);
      send(8'h22, 4'h0);
      expect_out(2'h1, 12'hB22, 12'h0);
      bus(1, IDX_SPECIAL_1, 32'h11);
      bus(1, IDX_SPECIAL_2, 32'h13);
      bus(1, IDX_CONTROL, 32'h2);
      bus(1, IDX_DETECT_THR, 32'h30);
      send(8'h13, 4'h0);
      expect_out(2'h0, 12'h0, 12'h0);
      `CK(nxoff, 1)
      bus(0, IDX_STATUS, 32'h0);
      `CK(rd, 32'h43)
      bus(1, IDX_DETECT_THR, 32'h10);
      stall <= 1;
      send(8'h11, 4'h0);
      stall <= 0;
      repeat (4) @(posedge MCLK);
      expect_out(2'h1, 12'h911, 12'h0);
      `CK(nxon, 1)
      bus(1, IDX_DETECT_THR, 32'h0);
      bus(1, IDX_STRIP_XLATE, 32'h83);
      send(8'hC1, 4'h0);
      expect_out(2'h1, 12'h041, 12'h0);
      // Newline with both transmit bits set leaves as return then newline
      @(posedge MCLK);
      {TX_IN_VALID, TX_IN_DATA} <= {1'b1, CH_NEWLINE};
      do @(posedge MCLK); while (TX_IN_READY !== 1'b1);
      TX_IN_VALID <= 1'b0;
      repeat (4) @(posedge MCLK);
      expect_out(2'h2, 12'h00D, 12'h00A);
      bus(1, IDX_CONTROL, 32'h0);
      drain <= 1;
      @(posedge MCLK);
      drain <= 0;
      bus(1, IDX_DETECT_THR, 32'h2);
      send(8'h31, 4'h0);
      `CK(DATA_REQ, 1'b0)
      send(8'h32, 4'h0);
      `CK(DATA_REQ, 1'b1)
      bus(1, IDX_CONTROL, 32'h1);
      repeat (2) @(posedge MCLK);
      `CK(DATA_REQ, 1'b1)
      bus(1, IDX_DETECT_THR, 32'h12);
      repeat (2) @(posedge MCLK);
      `CK(DATA_REQ, 1'b0)
      bus(1, IDX_DETECT_THR, 32'h0);
      repeat (2) @(posedge MCLK);
      `CK(DATA_REQ, 1'b0)
      test_done();
   end
endmodule : tb_top
